// ---- rtl/atqd_trigger.v ----
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "atqd_map.vh"
module atqd_trigger #(
  parameter TICK_CYC = `ATQD_CTICK
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [15:0] sample_data,
  input wire sample_valid,
  input wire dig_trig_in,
  output reg trig_pulse,
  output reg sample_go,
  output reg armed,
  output reg delay_ignored_warning
);
  // ***********************************************************
  // states
  // ***********************************************************
  localparam S_IDLE = 5'b00001;
  localparam S_WAIT = 5'b00010;
  localparam S_DELAY = 5'b00100;
  localparam S_HOLD = 5'b01000;
  localparam S_FAIL = 5'b10000;

  // ***********************************************************
  // registers
  // ***********************************************************
  reg [6:0] ctrl_r;
  reg [15:0] trig_threshold_code;
  reg [15:0] hyst_span;
  reg [31:0] timeout_r;
  reg [15:0] post_trig_wait_count;
  reg [3:0] rate_tb_r;
  reg [15:0] scan_divider;
  reg delay_err_r;
  reg timeout_r_hit;
  reg [4:0] state_r;
  reg ack_r;
  reg d1_r, d2_r, d3_r;
  reg hyst_ok_r;
  reg [31:0] tmo_cnt_r;
  reg [31:0] tick_cnt_r;
  reg [15:0] dly_cnt_r;
  reg [15:0] div_cnt_r;

  wire dig_trig_enable = ctrl_r[`ATQD_C_DIG_EN];
  wire dig_edge = ctrl_r[`ATQD_C_EDGE];
  wire ana_trig_enable = ctrl_r[`ATQD_C_ANA_EN];
  wire slope_select = ctrl_r[`ATQD_C_SLOPE];
  wire pre_mode = ctrl_r[`ATQD_C_PRE];
  wire w12 = ctrl_r[`ATQD_C_W12];
  wire sw_det = ctrl_r[`ATQD_C_SWDET];

  // a write lands at the edge where the master sees waitrequest low
  wire wr = avs_write && ack_r == 1'b1;
  wire wr_ctrl = wr && avs_address == `ATQD_CTRL && avs_byteenable[0];
  wire wr_dly = wr && avs_address == `ATQD_DELAY && avs_byteenable[0];
  wire wr_cmd = wr && avs_address == `ATQD_CMD && avs_byteenable[0];
  wire cmd_start = wr_cmd && avs_writedata[`ATQD_K_START];
  wire cmd_stop = wr_cmd && avs_writedata[`ATQD_K_STOP];
  wire cmd_rearm = wr_cmd && avs_writedata[`ATQD_K_REARM];
  wire cmd_clr = wr_cmd && avs_writedata[`ATQD_K_CLRST];

  // ***********************************************************
  // avalon slave: one wait cycle, then ack
  // ***********************************************************
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
      if (avs_read && !ack_r) begin
        case (avs_address)
          `ATQD_CTRL: avs_readdata <= {25'h0000000, ctrl_r};
          `ATQD_THRESH: avs_readdata <= {16'h0000, trig_threshold_code};
          `ATQD_HYST: avs_readdata <= {16'h0000, hyst_span};
          `ATQD_TIMEOUT: avs_readdata <= timeout_r;
          `ATQD_DELAY: avs_readdata <= {16'h0000, post_trig_wait_count};
          `ATQD_RATE: avs_readdata <= {12'h000, rate_tb_r, scan_divider};
          `ATQD_STATUS: avs_readdata <= {24'h000000, 1'b0, timeout_r_hit,
            delay_err_r, delay_ignored_warning, state_r[3:0]};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // byte-lane merge helper
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  wire [31:0] m_ctrl = merge({25'h0000000, ctrl_r}, avs_writedata,
    avs_byteenable);
  wire [31:0] m_thr = merge({16'h0000, trig_threshold_code}, avs_writedata,
    avs_byteenable);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `ATQD_RST_CTRL;
      trig_threshold_code <= 16'h0000;
      hyst_span <= 16'h0000;
      timeout_r <= `ATQD_RST_TIMEOUT;
      post_trig_wait_count <= 16'h0000;
      rate_tb_r <= `ATQD_RST_RATE_TB;
      scan_divider <= `ATQD_RST_SCANDIV;
      delay_err_r <= 1'b0;
      delay_ignored_warning <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= m_ctrl[6:0];
        if (m_ctrl[`ATQD_C_PRE] && !pre_mode &&
            post_trig_wait_count != 16'h0000) begin
          post_trig_wait_count <= 16'h0000;
          delay_err_r <= 1'b1;
        end
      end else if (cmd_clr) begin
        delay_err_r <= 1'b0;
      end
      if (wr && avs_address == `ATQD_THRESH)
        trig_threshold_code <= m_thr[15:0];
      if (wr && avs_address == `ATQD_HYST)
        hyst_span <= avs_writedata[15:0];
      if (wr && avs_address == `ATQD_TIMEOUT)
        timeout_r <= merge(timeout_r, avs_writedata, avs_byteenable);
      if (wr && avs_address == `ATQD_RATE) begin
        scan_divider <= avs_writedata[15:0];
        rate_tb_r <= avs_writedata[19:16];
      end
      if (wr_dly) begin
        if (pre_mode) begin
          delay_ignored_warning <= 1'b1;
        end else begin
          post_trig_wait_count <= avs_writedata[15:0];
          delay_ignored_warning <= 1'b0;
        end
      end else if (cmd_clr) begin
        delay_ignored_warning <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // input synchronisers and comparator
  // ***********************************************************
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      d1_r <= 1'b0;
      d2_r <= 1'b0;
      d3_r <= 1'b0;
    end else begin
      d1_r <= dig_trig_in;
      d2_r <= d1_r;
      d3_r <= d2_r;
    end
  end
  wire dig_hit = dig_trig_enable &&
    (dig_edge ? (d2_r && !d3_r) : (!d2_r && d3_r));

  // 12-bit codes are sign-extended from bit 11
  wire [15:0] thr = w12 ? {{4{trig_threshold_code[11]}},
    trig_threshold_code[11:0]} : trig_threshold_code;
  wire [15:0] smp = w12 ? {{4{sample_data[11]}}, sample_data[11:0]} :
    sample_data;
  wire [15:0] lim_lo = thr - hyst_span;
  wire [15:0] lim_hi = thr + hyst_span;
  // hardware comparison uses upper byte only
  wire [15:0] mask = sw_det ? 16'hFFFF : 16'hFF00;
  wire signed [15:0] s_s = $signed(smp);
  wire signed [15:0] t_s = $signed(thr & mask);
  wire signed [15:0] lo_s = $signed(lim_lo & mask);
  wire signed [15:0] hi_s = $signed(lim_hi & mask);
  wire arm_cond = slope_select ? (s_s <= lo_s) : (s_s >= hi_s);
  wire fire_cond = slope_select ? (s_s >= t_s) : (s_s <= t_s);
  wire ana_hit = ana_trig_enable && sample_valid && hyst_ok_r && fire_cond;

  // ***********************************************************
  // delay timebase: 12-bit codes or sample timebase/divider
  // ***********************************************************
  reg [31:0] tb_period;
  always @* begin
    case (rate_tb_r)
      4'hF: tb_period = `ATQD_C200;
      4'h1: tb_period = `ATQD_C1US;
      4'h2: tb_period = `ATQD_C10US;
      4'h3: tb_period = `ATQD_C100US;
      4'h4: tb_period = `ATQD_C1MS;
      4'h5: tb_period = `ATQD_C10MS;
      default: tb_period = `ATQD_C1US;
    endcase
  end
  wire tb_tick;
  // timebase restarts with each delay so the wait is whole periods
  wire in_delay = state_r == S_DELAY;
  atqd_period_gen atqd_period_gen_inst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(in_delay),
    .period(tb_period),
    .tick(tb_tick)
  );
  // 16-bit variants divide the sample timebase by the scan divider
  wire div_wrap = div_cnt_r + 16'h0001 >= scan_divider;
  wire dly_tick = w12 ? tb_tick : (tb_tick && div_wrap);
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) div_cnt_r <= 16'h0000;
    else if (!in_delay) div_cnt_r <= 16'h0000;
    else if (tb_tick) div_cnt_r <= div_wrap ? 16'h0000 :
      div_cnt_r + 16'h0001;
  end

  // ***********************************************************
  // trigger sequencer
  // ***********************************************************
  wire any_hw = dig_trig_enable || ana_trig_enable;
  wire hit = dig_hit || ana_hit;
  wire use_dly = !pre_mode && post_trig_wait_count != 16'h0000;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      trig_pulse <= 1'b0;
      sample_go <= 1'b0;
      armed <= 1'b0;
      hyst_ok_r <= 1'b0;
      tmo_cnt_r <= 32'h00000000;
      tick_cnt_r <= 32'h00000000;
      dly_cnt_r <= 16'h0000;
      timeout_r_hit <= 1'b0;
    end else begin
      trig_pulse <= 1'b0;
      sample_go <= 1'b0;
      if (cmd_clr) timeout_r_hit <= 1'b0;
      if (cmd_stop) begin
        state_r <= S_IDLE;
        armed <= 1'b0;
      end else begin
        case (state_r)
          S_IDLE: begin
            if (cmd_start) begin
              hyst_ok_r <= 1'b0;
              tmo_cnt_r <= 32'h00000000;
              tick_cnt_r <= 32'h00000000;
              if (!any_hw) begin
                trig_pulse <= 1'b1;
                state_r <= S_HOLD;
                sample_go <= 1'b1;
              end else begin
                armed <= 1'b1;
                state_r <= S_WAIT;
              end
            end
          end
          S_WAIT: begin
            if (sample_valid && arm_cond)
              hyst_ok_r <= 1'b1;
            if (hit) begin
              trig_pulse <= 1'b1;
              armed <= 1'b0;
              dly_cnt_r <= post_trig_wait_count;
              if (use_dly) state_r <= S_DELAY;
              else begin
                sample_go <= 1'b1;
                state_r <= S_HOLD;
              end
            end else if (sw_det && ana_trig_enable &&
                timeout_r != 32'hFFFFFFFF) begin
              if (tick_cnt_r + 32'h00000001 >= TICK_CYC) begin
                tick_cnt_r <= 32'h00000000;
                tmo_cnt_r <= tmo_cnt_r + 32'h00000001;
              end else begin
                tick_cnt_r <= tick_cnt_r + 32'h00000001;
              end
              if (tmo_cnt_r >= timeout_r) begin
                timeout_r_hit <= 1'b1;
                armed <= 1'b0;
                state_r <= S_FAIL;
              end
            end
          end
          S_DELAY: begin
            if (dly_tick) begin
              if (dly_cnt_r == 16'h0001) begin
                sample_go <= 1'b1;
                state_r <= S_HOLD;
              end
              dly_cnt_r <= dly_cnt_r - 16'h0001;
            end
          end
          S_HOLD: begin
            if (cmd_rearm) begin
              hyst_ok_r <= 1'b0;
              armed <= any_hw;
              state_r <= any_hw ? S_WAIT : S_IDLE;
            end
          end
          S_FAIL: begin
            if (cmd_start || cmd_rearm) state_r <= S_IDLE;
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end
endmodule // atqd_trigger

// ---- inc/atqd_map.vh ----
// Overview of operation
// - 12-bit variant: threshold is signed -2048..2047, 2.5 mV per code step.
// - 16-bit variants: threshold is signed 16-bit, -32768..32767 over 2.828 V.
// - Positive slope: arm at/below threshold minus span, fire at/above threshold.
// - Negative slope: arm at/above threshold plus span, fire at/below threshold.
// - Hardware comparator uses only the upper eight bits of threshold and limits.
// - Software-detected variant: timeout in 1/60 s ticks, -1 forever, 0 abandon.
// - Hardware-detected variants ignore timeout and stay armed indefinitely.
// - No trigger enabled: start command triggers at once, posttrigger only.
// - 12-bit variant, both triggers on: first one met wins for the frame.
// - Posttrigger: wait delay count of timebase periods; 0 immediate; 0,3..65535.
// - 12-bit delay timebase codes: -1 200ns, 1 1us ... 5 10ms, 0 reserved.
// - 16-bit variants: delay clocked by sample timebase over scan divider; code 0.
// - After reset sampling uses timebase code 1 with scan divider 1.
// - Default no delay; timebase ignored when delay count is zero.
// - Delay request under pretrigger capture is rejected with a warning.
// - Switching to pretrigger clears any programmed delay and flags an error.
// - Slope select 0 is negative-going, 1 is positive-going.
// - Digital edge 0 falling, 1 rising; effective only when enabled.
`ifndef ATQD_MAP_VH
`define ATQD_MAP_VH
// register byte offsets
`define ATQD_CTRL 8'h00
`define ATQD_THRESH 8'h04
`define ATQD_HYST 8'h08
`define ATQD_TIMEOUT 8'h0C
`define ATQD_DELAY 8'h10
`define ATQD_RATE 8'h14
`define ATQD_CMD 8'h18
`define ATQD_STATUS 8'h1C
// control field positions
`define ATQD_C_DIG_EN 0
`define ATQD_C_EDGE 1
`define ATQD_C_ANA_EN 2
`define ATQD_C_SLOPE 3
`define ATQD_C_PRE 4
`define ATQD_C_W12 5
`define ATQD_C_SWDET 6
// command bits
`define ATQD_K_START 0
`define ATQD_K_STOP 1
`define ATQD_K_REARM 2
`define ATQD_K_CLRST 3
// reset values
`define ATQD_RST_CTRL 7'h00
`define ATQD_RST_RATE_TB 4'h1
`define ATQD_RST_SCANDIV 16'h0001
`define ATQD_RST_TIMEOUT 32'hFFFFFFFF
// timing: period 4 ns, 200 ns and 1/60 s
`define ATQD_CLK_NS 4
`define ATQD_T200_NS 200
`define ATQD_TICK_NS 16666667
`define ATQD_C200 (`ATQD_T200_NS / `ATQD_CLK_NS)
`define ATQD_C1US 32'h000000FA
`define ATQD_C10US 32'h000009C4
`define ATQD_C100US 32'h000061A8
`define ATQD_C1MS 32'h0003D090
`define ATQD_C10MS 32'h002625A0
`define ATQD_CTICK (`ATQD_TICK_NS / `ATQD_CLK_NS)
`endif

// ---- rtl/atqd_period_gen.v ----
`timescale 1ns/1ps
// ***********************************************************
// programmable period enable: one pulse every 'period' cycles
// ***********************************************************
module atqd_period_gen (
  input wire sys_clk,
  input wire rst_n,
  input wire run,
  input wire [31:0] period,
  output reg tick
);
  reg [31:0] cnt_r;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 32'h00000000;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_r <= 32'h00000000;
      tick <= 1'b0;
    end else if (cnt_r + 32'h00000001 >= period) begin
      cnt_r <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule // atqd_period_gen

// ---- test/atqd_trigger_sva.sv ----
`timescale 1ns/1ps
// ***********************************************************
// port checker for the trigger block
// ***********************************************************
module atqd_chk (
  input wire sys_clk,
  input wire rst_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [15:0] sample_data,
  input wire sample_valid,
  input wire dig_trig_in,
  input wire trig_pulse,
  input wire sample_go,
  input wire armed,
  input wire delay_ignored_warning
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_wait_cause: assert property
    ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("waitrequest dropped without a request");
  a_unmapped_zero: assert property
    (!avs_waitrequest && avs_read && avs_address > 8'h1C
     |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_trig_single: assert property (trig_pulse |=> !trig_pulse)
    else $error("trigger pulse longer than one cycle");
  a_trig_holdoff: assert property (trig_pulse |=> !armed[*2])
    else $error("still armed after trigger");
  a_arm_cause: assert property ($rose(armed) |-> $past(avs_write))
    else $error("armed without a command");
  a_go_single: assert property (sample_go |=> !sample_go)
    else $error("sample start longer than one cycle");
  a_warn_cause: assert property
    ($rose(delay_ignored_warning) |-> $past(avs_write))
    else $error("warning raised without a write");
  a_warn_sticky: assert property
    (delay_ignored_warning && !avs_write |=> delay_ignored_warning)
    else $error("warning dropped without a write");
endmodule // atqd_chk

bind atqd_trigger atqd_chk atqd_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sample_data(sample_data), .sample_valid(sample_valid),
  .dig_trig_in(dig_trig_in), .trig_pulse(trig_pulse),
  .sample_go(sample_go), .armed(armed),
  .delay_ignored_warning(delay_ignored_warning));

// ---- test/atqd_sample_src.sv ----
`timescale 1ns/1ps
// ***********************************************************
// analog sample stream: one sample every four clocks
// ***********************************************************
module atqd_sample_src (
  input wire sys_clk,
  input wire rst_n,
  input wire [15:0] level,
  output reg [15:0] sample_data,
  output reg sample_valid
);
  reg [1:0] div_r;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 2'h0;
      sample_valid <= 1'h0;
      sample_data <= 16'h0000;
    end else begin
      div_r <= div_r + 2'h1;
      sample_valid <= (div_r == 2'h3);
      // between samples the data lines carry no held value
      sample_data <= (div_r == 2'h3) ? level : ~sample_data;
    end
  end
endmodule // atqd_sample_src

// ---- test/acq_trigger_qualify_and_delay_test.sv ----
`timescale 1ns/1ps
`include "atqd_map.vh"
module acq_trigger_qualify_and_delay_test;
  reg sys_clk;
  reg rst_n;
  reg [7:0] avs_address;
  reg avs_read;
  reg avs_write;
  reg [31:0] avs_writedata;
  reg dig_trig_in;
  reg [15:0] lvl;
  reg [31:0] rd_v;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [15:0] sample_data;
  wire sample_valid;
  wire trig_pulse;
  wire sample_go;
  wire armed;
  wire delay_ignored_warning;
  integer n_fail, comparisons, cyc, n_trig, n_go, t_trig, t_go, et, i, n;
  atqd_trigger #(.TICK_CYC(10)) atqd_trigger_inst (.sys_clk(sys_clk),
    .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sample_data(sample_data),
    .sample_valid(sample_valid), .dig_trig_in(dig_trig_in),
    .trig_pulse(trig_pulse), .sample_go(sample_go), .armed(armed),
    .delay_ignored_warning(delay_ignored_warning));
  atqd_sample_src atqd_sample_src_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .level(lvl), .sample_data(sample_data), .sample_valid(sample_valid));
  // ***********************************************************
  // clock, event monitor, watchdog
  // ***********************************************************
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (trig_pulse === 1'h1) begin
      n_trig <= n_trig + 1;
      t_trig <= cyc;
    end
    if (sample_go === 1'h1) begin
      n_go <= n_go + 1;
      t_go <= cyc;
    end
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_fail = n_fail + 1;
    summarize;
  end
  // ***********************************************************
  // tasks
  // ***********************************************************
  task summarize;
    begin
      if (n_fail == 0 && comparisons > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'h0)
        @(posedge sys_clk);
      rd_v = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
    end
  endtask
  task rchk(input [7:0] a, input [31:0] exp, input string nm);
    begin
      bus(1'h0, a, 32'h0);
      chk(nm, rd_v, exp);
    end
  endtask
  task waitc(input integer c);
    repeat (c) @(posedge sys_clk);
  endtask
  task start(input [31:0] ctrl);
    begin
      bus(1'h1, `ATQD_CMD, 32'h2);
      bus(1'h1, `ATQD_CTRL, ctrl);
      bus(1'h1, `ATQD_CMD, 32'h1);
      waitc(24);
    end
  endtask
  // ***********************************************************
  // tests
  // ***********************************************************
  initial begin
    {n_fail, comparisons, cyc, n_trig, n_go, t_trig, t_go} = 0;
    {avs_address, avs_read, avs_write, avs_writedata} = 0;
    dig_trig_in = 1'h0;
    lvl = 16'h0900;
    rst_n = 1'h0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'h1;
    rchk(`ATQD_CTRL, 32'h0, "ctrl");
    rchk(`ATQD_RATE, 32'h00010001, "rate");
    rchk(`ATQD_DELAY, 32'h0, "delay");
    rchk(`ATQD_TIMEOUT, 32'hFFFFFFFF, "timeout");
    rchk(8'h40, 32'h0, "unmapped");
    start(32'h0);
    chk("soft trig", n_trig, 1);
    chk("go with trig", t_go, t_trig);
    bus(1'h1, `ATQD_THRESH, 32'h08FF);
    bus(1'h1, `ATQD_HYST, 32'h0100);
    bus(1'h1, `ATQD_TIMEOUT, 32'h0);
    start(32'h0C);
    chk("no arm above", n_trig, 1);
    lvl <= 16'h0700;
    waitc(24);
    lvl <= 16'h0800;
    waitc(24);
    chk("pos fire", n_trig, 2);
    chk("pos go", t_go, t_trig);
    bus(1'h1, `ATQD_THRESH, 32'h0800);
    lvl <= 16'h0700;
    start(32'h04);
    chk("still armed", armed, 1);
    chk("no arm below", n_trig, 2);
    lvl <= 16'h0900;
    waitc(24);
    lvl <= 16'h0800;
    waitc(24);
    chk("neg fire", n_trig, 3);
    et = 3;
    for (i = 0; i < 2; i = i + 1) begin
      dig_trig_in <= (i == 0);
      start(32'h1 | (i << 1));
      chk("dig quiet", n_trig, et);
      dig_trig_in <= (i != 0);
      waitc(16);
      et = et + 1;
      chk("dig edge", n_trig, et);
    end
    start(32'h4C);
    chk("abandon", armed, 0);
    rchk(`ATQD_STATUS, 32'h40, "timeout flag");
    bus(1'h1, `ATQD_TIMEOUT, 32'hFFFFFFFF);
    start(32'h4C);
    waitc(40);
    chk("wait forever", armed, 1);
    bus(1'h1, `ATQD_DELAY, 32'h3);
    for (i = 1; i < 3; i = i + 1) begin
      dig_trig_in <= 1'h0;
      bus(1'h1, `ATQD_RATE, 32'h00010000 | i);
      start(32'h03);
      n = n_go;
      dig_trig_in <= 1'h1;
      et = 0;
      while (n_go == n && et < 3000) begin
        @(posedge sys_clk);
        et = et + 1;
      end
      et = 750 * i;
      chk("delay gap", (t_go - t_trig >= et - 1) && (t_go - t_trig <= et + 2),
        1);
    end
    bus(1'h1, `ATQD_HYST, 32'h0);
    bus(1'h1, `ATQD_THRESH, 32'h0F00);
    bus(1'h1, `ATQD_RATE, 32'h000F0005);
    lvl <= 16'h0100;
    start(32'h2C);
    chk("12b no arm", n_trig, 7);
    lvl <= 16'h5E00;
    waitc(24);
    lvl <= 16'h0100;
    waitc(200);
    chk("12b fire", n_trig, 8);
    chk("12b delay", t_go - t_trig, 151);
    start(32'h01);
    bus(1'h1, `ATQD_CTRL, 32'h11);
    rchk(`ATQD_DELAY, 32'h0, "delay cleared");
    bus(1'h0, `ATQD_STATUS, 32'h0);
    chk("delay err", rd_v[5], 1);
    bus(1'h1, `ATQD_DELAY, 32'h5);
    waitc(2);
    chk("warning set", delay_ignored_warning, 1);
    rchk(`ATQD_DELAY, 32'h0, "delay refused");
    bus(1'h1, `ATQD_CMD, 32'h8);
    waitc(2);
    chk("warning clear", delay_ignored_warning, 0);
    summarize;
  end
endmodule // acq_trigger_qualify_and_delay_test
